// ===== core/afe_link_if.sv
// Register link between the controller and the front-end setup bank
`timescale 1ns/10ps
`default_nettype none
interface afe_link_if (
    input wire logic aclk
);
    logic       req;
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;

    modport ctrl (
        input  aclk,
        output req,
        output wr,
        output addr,
        output wdata,
        input  rdata,
        input  ack
    );
    modport dev (
        input  aclk,
        input  req,
        input  wr,
        input  addr,
        input  wdata,
        output rdata,
        output ack
    );
endinterface
`default_nettype wire

// ===== core/afe_pkg.sv
// Shared constants for the front-end setup bank and its controller
package afe_pkg;
    // Device register offsets on the link
    localparam logic [5:0] PRIMARY_ADDR   = 6'h01;
    localparam logic [5:0] OUTPUT_ADDR    = 6'h02;
    localparam logic [5:0] LAMP_ADDR      = 6'h24;
    localparam logic [5:0] REVISION_ADDR  = 6'h27;
    // Reset values
    localparam logic [7:0] PRIMARY_RST    = 8'h03;
    localparam logic [7:0] OUTPUT_RST     = 8'h00;
    localparam logic [7:0] LAMP_RST       = 8'h00;
    // Primary setup fields
    localparam int POWER_BIT       = 0;
    localparam int DOUBLE_BIT      = 1;
    localparam int DETECT_BIT      = 3;
    localparam int SHIFT_LSB       = 4;
    localparam int THIRD_MODE_BIT  = 6;
    localparam int PAGE_OPEN_BIT   = 7;
    // Output setup fields
    localparam int POLARITY_BIT    = 0;
    localparam int NARROW_BIT      = 1;
    localparam int INVERT_BIT      = 2;
    localparam int CLAMP_EXT_BIT   = 3;
    localparam int CLAMP_EN_BIT    = 4;
    localparam int LATENCY_LSB     = 6;
    // Extended page fields
    localparam int LAMP_LSB        = 2;
    localparam int REVISION_LSB    = 1;
    localparam logic [7:0] LAMP_MASK      = 8'h3c;
    // Reserved bits cleared by the controller
    localparam logic [7:0] PRIMARY_KEEP   = 8'h3b;
    localparam logic [7:0] OUTPUT_KEEP    = 8'hdf;
    // Master clocks per converter clock
    localparam int CONV_DIV_STD    = 2;
    localparam int CONV_DIV_SECOND = 3;
    // Latency codes
    localparam logic [1:0] LAT_TWO        = 2'h2;
    localparam logic [1:0] LAT_THREE      = 2'h3;
    // Controller register offsets on AXI4-Lite
    localparam logic [3:0] CMD_OFF        = 4'h0;
    localparam logic [3:0] STATUS_OFF     = 4'h4;
    localparam logic [3:0] MODE_OFF       = 4'h8;
    // Command and status word fields
    localparam int CMD_ADDR_LSB    = 8;
    localparam int CMD_READ_BIT    = 16;
    localparam int CMD_EXT_BIT     = 17;
    localparam int STATUS_DATA_LSB = 8;
endpackage

// ===== core/afe_setup_bank.sv
// Setup register bank of the analogue front end, device end
//
// The implementer's own choice: register access over the afe_link_if request/acknowledge link.
`timescale 1ns/10ps
`default_nettype none
module afe_setup_bank #(
    parameter int           DATA_W   = 16,
    parameter logic [6:0]   REVISION = 7'h01  // Arbitrary value
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    afe_link_if.dev                link,
    input  wire logic              video_sample_pin,
    input  wire logic              second_mode,
    input  wire logic [DATA_W-1:0] sample_data,
    output logic                   power_active,
    output logic                   double_sample_select,
    output logic                   amp_fs_positive,
    output logic                   amp_fs_negative,
    output logic                   third_mode_select,
    output logic                   timing_pulse,
    output logic                   narrow_output_select,
    output logic                   clamp_ref_converter_on,
    output logic                   clamp_ref_pin_oe,
    output logic                   reset_clamp_enable,
    output logic [3:0]             lamp_test_field,
    output logic                   conv_tick,
    output logic [DATA_W-1:0]      data_out
);
    logic [7:0]        primary_setup_ff;
    logic [7:0]        output_setup_ff;
    logic [7:0]        lamp_test_control_ff;
    logic [7:0]        rdata_ff;
    logic              ack_ff;
    logic [7:0]        nxt_rdata;
    logic              page_open;
    logic              sel_primary;
    logic              sel_output;
    logic              sel_lamp;
    logic              sel_revision;
    logic [2:0]        pin_sync_ff;
    logic              pin_level_ff;
    logic              pin_rise;
    logic              pin_fall;
    logic              detect_en;
    logic [1:0]        conv_cnt_ff;
    logic [1:0]        conv_last;
    logic              tick;
    logic [DATA_W-1:0] pipe_ff [3];
    logic [DATA_W-1:0] nxt_data;
    logic [1:0]        latency;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    assign page_open    = primary_setup_ff[afe_pkg::PAGE_OPEN_BIT];
    assign sel_primary  = link.addr == afe_pkg::PRIMARY_ADDR;
    assign sel_output   = link.addr == afe_pkg::OUTPUT_ADDR;
    assign sel_lamp     = page_open && link.addr == afe_pkg::LAMP_ADDR;
    assign sel_revision = page_open && link.addr == afe_pkg::REVISION_ADDR;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primary_setup_ff <= afe_pkg::PRIMARY_RST;
        end else if (link.req && link.wr && sel_primary) begin
            primary_setup_ff <= link.wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_setup_ff <= afe_pkg::OUTPUT_RST;
        end else if (link.req && link.wr && sel_output) begin
            output_setup_ff <= link.wdata;
        end
    end

    // Unused bits kept zero so reads show only the field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lamp_test_control_ff <= afe_pkg::LAMP_RST;
        end else if (link.req && link.wr && sel_lamp) begin
            lamp_test_control_ff <= link.wdata & afe_pkg::LAMP_MASK;
        end
    end

    // Revision has no write path; unmapped reads give zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (sel_primary) begin
            nxt_rdata = primary_setup_ff;
        end else if (sel_output) begin
            nxt_rdata = output_setup_ff;
        end else if (sel_lamp) begin
            nxt_rdata = lamp_test_control_ff;
        end else if (sel_revision) begin
            nxt_rdata = {REVISION, 1'b0};
        end
    end

    // Every request answered one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= link.req;
            if (link.req && !link.wr) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign link.ack   = ack_ff;
    assign link.rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Sample pin synchroniser and filter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_ff  <= 3'h0;
            pin_level_ff <= 1'b0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], video_sample_pin};
            if (pin_sync_ff[1] == pin_sync_ff[2]) begin
                pin_level_ff <= pin_sync_ff[2];
            end
        end
    end

    assign pin_rise  = pin_sync_ff[1] && pin_sync_ff[2] && !pin_level_ff;
    assign pin_fall  = !pin_sync_ff[1] && !pin_sync_ff[2] && pin_level_ff;
    assign detect_en = primary_setup_ff[afe_pkg::DETECT_BIT];

    // Powered-down device issues no timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timing_pulse <= 1'b0;
        end else if (!primary_setup_ff[afe_pkg::POWER_BIT]) begin
            timing_pulse <= 1'b0;
        end else if (!detect_en) begin
            timing_pulse <= pin_level_ff;
        end else if (output_setup_ff[afe_pkg::POLARITY_BIT]) begin
            timing_pulse <= pin_rise;
        end else begin
            timing_pulse <= pin_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter clock
    assign conv_last = second_mode ? 2'(afe_pkg::CONV_DIV_SECOND - 1)
                                   : 2'(afe_pkg::CONV_DIV_STD - 1);
    assign tick      = conv_cnt_ff >= conv_last;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_cnt_ff <= 2'h0;
            conv_tick   <= 1'b0;
        end else begin
            conv_cnt_ff <= tick ? 2'h0 : conv_cnt_ff + 2'h1;
            conv_tick   <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output data latency and inversion
    assign latency = output_setup_ff[afe_pkg::LATENCY_LSB +: 2];

    always_comb begin
        case (latency)
            afe_pkg::LAT_TWO:   nxt_data = pipe_ff[1];
            afe_pkg::LAT_THREE: nxt_data = pipe_ff[2];
            default:            nxt_data = sample_data;
        endcase
        if (output_setup_ff[afe_pkg::INVERT_BIT]) begin
            nxt_data = ~nxt_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pipe_ff[0] <= '0;
            pipe_ff[1] <= '0;
            pipe_ff[2] <= '0;
            data_out   <= '0;
        end else if (tick) begin
            pipe_ff[0] <= sample_data;
            pipe_ff[1] <= pipe_ff[0];
            pipe_ff[2] <= pipe_ff[1];
            data_out   <= primary_setup_ff[afe_pkg::POWER_BIT] ? nxt_data
                                                              : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Static controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_active           <= 1'b0;
            double_sample_select   <= 1'b0;
            amp_fs_positive        <= 1'b0;
            amp_fs_negative        <= 1'b0;
            third_mode_select      <= 1'b0;
            narrow_output_select   <= 1'b0;
            clamp_ref_converter_on <= 1'b0;
            clamp_ref_pin_oe       <= 1'b0;
            reset_clamp_enable     <= 1'b0;
            lamp_test_field        <= 4'h0;
        end else begin
            power_active         <= primary_setup_ff[afe_pkg::POWER_BIT];
            double_sample_select <= primary_setup_ff[afe_pkg::DOUBLE_BIT];
            amp_fs_positive      <= primary_setup_ff[afe_pkg::SHIFT_LSB +: 2]
                                    == 2'h2;
            amp_fs_negative      <= primary_setup_ff[afe_pkg::SHIFT_LSB +: 2]
                                    == 2'h3;
            third_mode_select    <= primary_setup_ff[afe_pkg::THIRD_MODE_BIT];
            narrow_output_select <= output_setup_ff[afe_pkg::NARROW_BIT];
            clamp_ref_converter_on <= !output_setup_ff[afe_pkg::CLAMP_EXT_BIT]
                                      && primary_setup_ff[afe_pkg::POWER_BIT];
            clamp_ref_pin_oe       <= !output_setup_ff[afe_pkg::CLAMP_EXT_BIT]
                                      && primary_setup_ff[afe_pkg::POWER_BIT];
            reset_clamp_enable   <= output_setup_ff[afe_pkg::CLAMP_EN_BIT];
            lamp_test_field      <= lamp_test_control_ff[afe_pkg::LAMP_LSB +: 4];
        end
    end
endmodule
`default_nettype wire

// ===== core/afe_setup_ctrl.sv
// Controller end: AXI4-Lite command registers driving the setup link
`timescale 1ns/10ps
`default_nettype none
module afe_setup_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    afe_link_if.ctrl         link,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} state_t;

    state_t      state_ff;
    logic [1:0]  step_ff;
    logic        ext_ff;
    logic        rd_ff;
    logic [5:0]  addr_ff;
    logic [7:0]  data_ff;
    logic [7:0]  shadow_ff;
    logic [7:0]  result_ff;
    logic        third_mode_ff;
    logic [3:0]  awaddr_ff;
    logic [31:0] wdata_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic        do_write;
    logic        bad_wr;
    logic [5:0]  nxt_addr;
    logic [7:0]  nxt_wdata;
    logic        nxt_wr;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side; address and data taken in either order
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign bad_wr   = awaddr_ff != afe_pkg::CMD_OFF
                      && awaddr_ff != afe_pkg::MODE_OFF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= 4'h0;
            wdata_ff      <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held_ff && !s_axi_awready;
            s_axi_wready  <= !w_held_ff && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
            end
            if (do_write) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= bad_wr ? 2'h2 : 2'h0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            third_mode_ff <= 1'b0;
        end else if (do_write && awaddr_ff == afe_pkg::MODE_OFF
                     && s_axi_wstrb[0]) begin
            third_mode_ff <= wdata_ff[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    afe_pkg::STATUS_OFF:
                        s_axi_rdata <= {16'h0, result_ff,
                                        7'h0, state_ff != ST_IDLE};
                    afe_pkg::MODE_OFF:
                        s_axi_rdata <= {31'h0, third_mode_ff};
                    afe_pkg::CMD_OFF:
                        s_axi_rdata <= {14'h0, ext_ff, rd_ff,
                                        2'h0, addr_ff, data_ff};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer: extended commands open page, access, close page; others only access
    always_comb begin
        nxt_addr  = addr_ff;
        nxt_wr    = !rd_ff;
        nxt_wdata = data_ff;
        if (step_ff == 2'h0) begin
            nxt_addr  = afe_pkg::PRIMARY_ADDR;
            nxt_wr    = 1'b1;
            nxt_wdata = shadow_ff | 8'h80;
        end else if (step_ff == 2'h2) begin
            nxt_addr  = afe_pkg::PRIMARY_ADDR;
            nxt_wr    = 1'b1;
            nxt_wdata = shadow_ff;
        end else if (addr_ff == afe_pkg::PRIMARY_ADDR) begin
            nxt_wdata = (data_ff & afe_pkg::PRIMARY_KEEP)
                        | {1'b0, third_mode_ff, 6'h0};
        end else if (addr_ff == afe_pkg::OUTPUT_ADDR) begin
            nxt_wdata = data_ff & afe_pkg::OUTPUT_KEEP;
        end
    end

    // Commands arriving while busy are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff   <= ST_IDLE;
            step_ff    <= 2'h1;
            ext_ff     <= 1'b0;
            rd_ff      <= 1'b0;
            addr_ff    <= 6'h0;
            data_ff    <= 8'h00;
            shadow_ff  <= afe_pkg::PRIMARY_RST;
            result_ff  <= 8'h00;
            link.req   <= 1'b0;
            link.wr    <= 1'b0;
            link.addr  <= 6'h0;
            link.wdata <= 8'h00;
        end else begin
            link.req <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (do_write && awaddr_ff == afe_pkg::CMD_OFF) begin
                        ext_ff   <= wdata_ff[afe_pkg::CMD_EXT_BIT];
                        rd_ff    <= wdata_ff[afe_pkg::CMD_READ_BIT];
                        addr_ff  <= wdata_ff[afe_pkg::CMD_ADDR_LSB +: 6];
                        data_ff  <= wdata_ff[7:0];
                        step_ff  <= wdata_ff[afe_pkg::CMD_EXT_BIT] ? 2'h0
                                                                   : 2'h1;
                        state_ff <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    link.req   <= 1'b1;
                    link.wr    <= nxt_wr;
                    link.addr  <= nxt_addr;
                    link.wdata <= nxt_wdata;
                    if (nxt_wr && nxt_addr == afe_pkg::PRIMARY_ADDR
                        && step_ff == 2'h1) begin
                        shadow_ff <= nxt_wdata;
                    end
                    state_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (link.ack) begin
                        if (step_ff == 2'h1 && rd_ff) begin
                            result_ff <= link.rdata;
                        end
                        if (step_ff == 2'h2 || (step_ff == 2'h1 && !ext_ff))
                        begin
                            state_ff <= ST_IDLE;
                        end else begin
                            step_ff  <= step_ff + 2'h1;
                            state_ff <= ST_ISSUE;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== test/afe_setup_control_bank_tb.sv
// Testbench: AXI controller and setup bank joined over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module afe_setup_control_bank_tb;
    localparam logic [6:0] REV = 7'h05;  // Arbitrary value
    logic        aclk, aresetn, video_sample_pin, second_mode;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, lamp_test_field;
    logic [31:0] s_axi_wdata, s_axi_rdata, st;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, power_active, timing_pulse;
    logic        double_sample_select, amp_fs_positive, amp_fs_negative;
    logic        third_mode_select, narrow_output_select, reset_clamp_enable;
    logic        clamp_ref_converter_on, clamp_ref_pin_oe, conv_tick;
    logic [15:0] sample_data, data_out, v, hist[$];
    logic [7:0]  q, d, e;
    integer      errors = 0, n_checks = 0, seed = 32'h998a9c33, n;
    integer      prim_m = 8'h03, out_m = 0, mode_m = 0;
    int          lat_q[$] = {8'h80, 8'hc4, 8'h44};
    afe_link_if link (.aclk(aclk));
    afe_setup_ctrl u_afe_setup_ctrl (.*);
    afe_setup_bank #(.REVISION(REV)) u_afe_setup_bank (.*);
    afe_setup_sva #(.REVISION(REV)) u_afe_setup_sva (.aclk(aclk),
        .aresetn(aresetn), .req(link.req), .wr(link.wr), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
    ////////////////////////////////////////////////////////////////////////
    task automatic axi_w(input logic [3:0] a, input logic [31:0] dw);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, dw, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        forever begin
            @(posedge aclk);
            s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_r(input logic [3:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        forever begin
            @(posedge aclk);
            s_axi_arvalid <= s_axi_arvalid & ~s_axi_arready;
            if (s_axi_rvalid) break;
        end
        {st, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic cmd(input bit x, r, input logic [5:0] a, logic [7:0] b);
        axi_w(afe_pkg::CMD_OFF, {14'h0, x, r, 2'b0, a, b});
        do axi_r(afe_pkg::STATUS_OFF); while (st[0] !== 1'b0);
        q = st[15:8];
    endtask
    task automatic tally(input bit tick);
        n = 0;
        repeat (12) begin
            @(posedge aclk);
            n += tick ? conv_tick : timing_pulse;
        end
    endtask
    task automatic chk_all;
        cmd(0, 1, afe_pkg::PRIMARY_ADDR, 8'h00);
        `CHK("primary", prim_m[7:0], q)
        cmd(0, 1, afe_pkg::OUTPUT_ADDR, 8'h00);
        `CHK("output", out_m[7:0], q)
        `CHK("power", prim_m[0], power_active)
        `CHK("double", prim_m[1], double_sample_select)
        `CHK("shift", {prim_m[5:4] == 3, prim_m[5:4] == 2},
            {amp_fs_negative, amp_fs_positive})
        `CHK("third", prim_m[6], third_mode_select)
        `CHK("narrow", out_m[1], narrow_output_select)
        `CHK("clamp", out_m[4], reset_clamp_enable)
        `CHK("conv", {2{!out_m[3] && prim_m[0]}},
            {clamp_ref_converter_on, clamp_ref_pin_oe})
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        // Roughly 800 cycles are needed; the 15000-cycle limit means a hang
        #60000;
        errors++;
        conclude();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, sample_data} = '0;
        {s_axi_arvalid, s_axi_rready, video_sample_pin, second_mode} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk_all();
        for (int p = 0; p < 2; p++) begin
            video_sample_pin <= p[0];
            repeat (8) @(posedge aclk);
            `CHK("pin level", p[0], timing_pulse)
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[5:4] = i[1:0];
            e = 8'($random(seed));
            axi_w(afe_pkg::MODE_OFF, {31'h0, i[2]});
            mode_m = i[2];
            cmd(0, 0, afe_pkg::PRIMARY_ADDR, d);
            cmd(0, 0, afe_pkg::OUTPUT_ADDR, e);
            prim_m = (d & 8'h3b) | (mode_m << 6);
            out_m = e & 8'hdf;
            chk_all();
        end
        $display("register test done");
        e = 8'($random(seed));
        cmd(1, 0, afe_pkg::LAMP_ADDR, e);
        `CHK("lamp", e[5:2], lamp_test_field)
        cmd(1, 1, afe_pkg::LAMP_ADDR, 8'h00);
        `CHK("lamp read", e & afe_pkg::LAMP_MASK, q)
        cmd(1, 0, afe_pkg::REVISION_ADDR, 8'hff);
        cmd(1, 1, afe_pkg::REVISION_ADDR, 8'h00);
        `CHK("revision", REV, q[7:1])
        cmd(0, 1, afe_pkg::REVISION_ADDR, 8'h00);
        `CHK("closed read", 8'h00, q)
        cmd(0, 0, afe_pkg::LAMP_ADDR, ~e);
        `CHK("closed write", e[5:2], lamp_test_field)
        chk_all();
        axi_w(4'hc, 32'h0);
        `CHK("bresp", 2'b10, rs)
        axi_r(4'hc);
        `CHK("rresp", 2'b10, rs)
        $display("page test done");
        cmd(0, 0, afe_pkg::PRIMARY_ADDR, 8'h0b);
        for (int p = 0; p < 4; p++) begin
            if (!p[0]) begin
                video_sample_pin <= ~p[1];
                cmd(0, 0, afe_pkg::OUTPUT_ADDR, {7'h0, p[1]});
            end
            video_sample_pin <= p[1] ^ p[0];
            tally(1'b0);
            `CHK("edge pulses", 32'(!p[0]), n)
        end
        $display("pulse test done");
        foreach (lat_q[k]) begin
            cmd(0, 0, afe_pkg::OUTPUT_ADDR, 8'(lat_q[k]));
            second_mode <= k[0];
            tally(1'b1);
            `CHK("ticks", k[0] ? 4 : 6, n)
            v = {16{lat_q[k][2]}};
            e = lat_q[k][7:6] > 1 ? lat_q[k][7:6] : 2'h0;
            hist.delete();
            repeat (40) begin
                @(posedge aclk);
                if (conv_tick) hist.push_front(sample_data);
                if (conv_tick) sample_data <= 16'($random(seed));
                if (conv_tick && hist.size() > 3)
                    `CHK("data", hist[e] ^ v, data_out)
            end
        end
        cmd(0, 0, afe_pkg::PRIMARY_ADDR, 8'h00);
        repeat (20) @(posedge aclk);
        `CHK("down data", 16'h0, data_out)
        `CHK("down", 2'b00, {power_active, clamp_ref_pin_oe})
        $display("output test done");
        conclude();
    end
endmodule
`default_nettype wire

// ===== test/afe_setup_sva.sv
// Link assertions for the setup controller and setup bank
`timescale 1ns/10ps
`default_nettype none
module afe_setup_sva #(
    parameter logic [6:0] REVISION = 7'h01
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       req,
    input wire logic       wr,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic page_ff;
    logic ext;
    logic prim_wr;
    assign ext = addr == afe_pkg::LAMP_ADDR || addr == afe_pkg::REVISION_ADDR;
    assign prim_wr = req && wr && addr == afe_pkg::PRIMARY_ADDR;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk)
        page_ff <= !aresetn ? 1'b0 : prim_wr ? wdata[7] : page_ff;
    ////////////////////////////////////////////////////////////////////////
    a_ack_follows: assert property (req |=> ack ##1 !ack)
        else $error("ack not one cycle after req");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without req");
    a_req_pulse: assert property (req |=> !req)
        else $error("req longer than one cycle");
    a_closed_read: assert property (
        req && !wr && ext && !page_ff |=> rdata == 8'h00)
        else $error("closed page read not zero");
    a_rev_field: assert property (
        req && !wr && addr == afe_pkg::REVISION_ADDR && page_ff
        |=> rdata[7:1] == REVISION)
        else $error("revision field wrong");
    a_page_close: assert property (
        req && ext && page_ff |-> ##[2:9] (prim_wr && !wdata[7]))
        else $error("page left open");
    a_reserved_zero: assert property (
        req && wr |-> !(addr == afe_pkg::PRIMARY_ADDR && wdata[2])
        && !(addr == afe_pkg::OUTPUT_ADDR && wdata[5]))
        else $error("reserved bit written as one");
    a_rdata_hold: assert property (!ack |-> $stable(rdata))
        else $error("rdata changed without ack");
    c_ext_read: cover property (req && !wr && ext && page_ff);
    c_closed: cover property (req && ext && !page_ff);
    c_page_open: cover property (prim_wr && wdata[7]);
endmodule
`default_nettype wire
